// ==== power_mode_pkg.sv ====
// Package for the power mode and wake-up controller.
// Assumes a single 10 MHz system clock and an AXI4-Lite register bus.
package power_mode_pkg;

   // System clock rate and reset delay time
   localparam int unsigned CLK_HZ            = 10_000_000;
   localparam int unsigned RESET_DELAY_MS    = 50;
   localparam int unsigned RESET_DELAY_CYC   =
      (RESET_DELAY_MS * (CLK_HZ / 1000) < 1) ? 1 :
      RESET_DELAY_MS * (CLK_HZ / 1000);

   // Oscillator start-up delays in system clocks
   localparam int unsigned SHORT_STARTUP_CYC = 2;
   localparam int unsigned LONG_STARTUP_CYC  = 128;

   // Register byte offsets
   localparam logic [7:0] CTRL_ZERO_OFS  = 8'h00;
   localparam logic [7:0] CTRL_TWO_OFS   = 8'h04;
   localparam logic [7:0] CTRL_FOUR_OFS  = 8'h08;
   localparam logic [7:0] STATUS_OFS     = 8'h0C;
   localparam logic [7:0] WAKE_EN_OFS    = 8'h10;
   localparam logic [7:0] CONFIG_OFS     = 8'h14;

   // Field positions
   localparam int unsigned SRC_SEL_BIT   = 0;
   localparam int unsigned KEEPALIVE_BIT = 0;
   localparam int unsigned XTAL_PWR_BIT  = 4;
   localparam int unsigned PDF_BIT       = 0;
   localparam int unsigned TO_BIT        = 1;
   localparam int unsigned MODE_LSB      = 4;

   // Values after reset
   localparam logic       SRC_SEL_RST    = 1'b0;
   localparam logic       KEEPALIVE_RST  = 1'b1;
   localparam logic       XTAL_PWR_RST   = 1'b0;
   localparam logic [7:0] WAKE_EN_RST    = 8'h00;
   localparam logic [3:0] CONFIG_RST     = 4'h0;

   // AXI responses
   localparam logic [1:0] RESP_OKAY      = 2'h0;
   localparam logic [1:0] RESP_SLVERR    = 2'h2;

   // Configuration options held in the config register
   typedef struct packed {
      logic hs_is_crystal;   // High-speed osc is a crystal
      logic sub_from_rc;     // Sub clock taken from low-speed RC
      logic wdt_en;          // Watchdog enabled
      logic lvr_en;          // Low-voltage reset enabled
   } pwr_cfg_t;

   // Operating state, one-hot
   typedef enum logic [3:0] {
      ST_RUN    = 4'h1,
      ST_HALT   = 4'h2,
      ST_WAKE   = 4'h4,
      ST_POR    = 4'h8
   } pwr_state_t;

   // Cause of the last wake-up
   typedef enum logic [1:0] {
      WK_RESUME = 2'h0,
      WK_INTR   = 2'h1,
      WK_WDT    = 2'h2,
      WK_POR    = 2'h3
   } wake_cause_t;

endpackage

// ==== power_mode_ctrl.sv ====
// Power mode and wake-up controller with AXI4-Lite register access.
// Assumes halt, clear-watchdog, interrupt and watchdog inputs come from
// logic on clk; the port A pins are asynchronous and are synchronised.

// Operation
// - Power-on clears the crystal power select bit, giving quick start.
// - Setting crystal power select keeps oscillator running at low current.
// - Low-speed RC runs if LVR, watchdog or RC sub clock is enabled.
// - Watchdog RC oscillator keeps running in Idle and Sleep.
// - Source select bit picks high-speed (Normal) or crystal (Slow) clock.
// - Keep-alive bit decides if low-speed crystal runs after halt.
// - Idle and Sleep always stop the high-speed system clock.
// - Halt enters Idle with crystal running, Sleep without it.
// - Halt entry behaves the same in Normal and Slow mode.
// - Sleep stops execution and holds memory, registers and ports.
// - Halt clears the watchdog counter, which restarts from zero.
// - Halt sets the power-down flag and clears the time-out flag.
// - Wake on power-on, enabled port A fall, interrupt or watchdog.
// - Power-on wake fully resets; watchdog wake sets time-out, resets PC/SP.
// - Power-down flag cleared by power-up or clear-watchdog, set by halt.
// - Enabled port A falling edge wakes; execution resumes after halt.
// - Disabled or stack-full interrupt wake resumes after halt, stays pending.
// - Enabled interrupt with stack room gets normal response on wake; a same-cycle watchdog overflow or port A wake takes priority.
// - Interrupt already flagged at halt entry cannot wake the device.
// - Wake delay 2 clocks for RC, 128 for crystal; Slow mode by keep-alive.
// - Power-on or LVR wake adds the reset delay before start-up delay.
// - Keep-alive bit is bit 0; 0 Sleep, 1 Idle.
// - Crystal power select is bit 4; 0 quick start, 1 low power.
module power_mode_ctrl
   import power_mode_pkg::*;
#(
   parameter int unsigned NUM_IRQ       = 8,
   parameter int unsigned RESET_DLY_CYC = RESET_DELAY_CYC
)
(
   input  wire logic               clk,
   input  wire logic               rst_n,
   input  wire logic               clk_en,
   // AXI4-Lite slave
   input  wire logic [7:0]         s_axi_awaddr,
   input  wire logic               s_axi_awvalid,
   output logic                    s_axi_awready,
   input  wire logic [31:0]        s_axi_wdata,
   input  wire logic [3:0]         s_axi_wstrb,
   input  wire logic               s_axi_wvalid,
   output logic                    s_axi_wready,
   output logic [1:0]              s_axi_bresp,
   output logic                    s_axi_bvalid,
   input  wire logic               s_axi_bready,
   input  wire logic [7:0]         s_axi_araddr,
   input  wire logic               s_axi_arvalid,
   output logic                    s_axi_arready,
   output logic [31:0]             s_axi_rdata,
   output logic [1:0]              s_axi_rresp,
   output logic                    s_axi_rvalid,
   input  wire logic               s_axi_rready,
   // CPU core side
   input  wire logic               halt_req,
   input  wire logic               clr_wdt_req,
   input  wire logic               wdt_overflow,
   input  wire logic               lvr_event,
   input  wire logic [NUM_IRQ-1:0] irq_flag,
   input  wire logic [NUM_IRQ-1:0] irq_enable,
   input  wire logic               stack_full,
   input  wire logic [7:0]         port_a_pin,
   // Oscillator and core control
   output logic                    highspeed_osc_en,
   output logic                    lowspeed_crystal_osc_en,
   output logic                    lowspeed_xtal_power_sel,
   output logic                    lowspeed_rc_osc_en,
   output logic                    sysclk_source_sel,
   output logic                    cpu_hold,
   output logic                    wdt_clear,
   output logic                    resume_after_halt,
   output logic                    intr_response,
   output logic                    pc_sp_reset,
   output logic                    power_down_flag,
   output logic                    watchdog_timeout_flag
);

   // Start-up delay for a wake-up from halt
   function automatic logic [31:0] startup_cyc(input logic slow,
                                               input logic keep,
                                               input logic xtal);
      if (slow)
         startup_cyc = keep ? SHORT_STARTUP_CYC : LONG_STARTUP_CYC;
      else
         startup_cyc = xtal ? LONG_STARTUP_CYC : SHORT_STARTUP_CYC;
   endfunction

   // Reset synchroniser
   logic rst_meta_q;
   logic rst_sync_n;

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         rst_meta_q <= 1'b0;
         rst_sync_n <= 1'b0;
      end
      else
      begin
         rst_meta_q <= 1'b1;
         rst_sync_n <= rst_meta_q;
      end
   end

   // Register state
   logic        src_sel_q;
   logic        keep_q;
   logic        xtal_pwr_q;
   logic [7:0]  wake_en_q;
   pwr_cfg_t    cfg_q;
   logic        pdf_q;
   logic        to_q;
   pwr_state_t  state_q;
   pwr_state_t  state_d;
   wake_cause_t cause_q;
   logic [31:0] cnt_q;
   logic [NUM_IRQ-1:0] irq_arm_q;

   // Port A synchroniser and edge history
   logic [7:0]  pa_meta_q;
   logic [7:0]  pa_sync_q;
   logic [7:0]  pa_prev_q;

   always_ff @(posedge clk or negedge rst_sync_n)
   begin
      if (!rst_sync_n)
      begin
         pa_meta_q <= 8'hFF;
         pa_sync_q <= 8'hFF;
         pa_prev_q <= 8'hFF;
      end
      else if (clk_en)
      begin
         pa_meta_q <= port_a_pin;
         pa_sync_q <= pa_meta_q;
         pa_prev_q <= pa_sync_q;
      end
   end

   // Wake sources
   wire [7:0] pa_fall  = pa_prev_q & ~pa_sync_q;
   wire       pa_wake  = |(pa_fall & wake_en_q);
   // flags set before halt are not armed
   wire [NUM_IRQ-1:0] irq_wake_v = irq_flag & irq_arm_q;
   wire       irq_wake = |irq_wake_v;
   wire       irq_serve = |(irq_wake_v & irq_enable) & ~stack_full;
   wire       in_halt  = (state_q == ST_HALT);
   wire       halt_go  = (state_q == ST_RUN) && halt_req;

   // AXI write channel
   logic        aw_have_q;
   logic        w_have_q;
   logic [7:0]  aw_addr_q;
   logic [31:0] w_data_q;
   logic [3:0]  w_strb_q;
   logic        bvalid_q;
   logic [1:0]  bresp_q;

   wire aw_take  = s_axi_awvalid && !aw_have_q && !bvalid_q;
   wire w_take   = s_axi_wvalid && !w_have_q && !bvalid_q;
   wire wr_go    = aw_have_q && w_have_q && !bvalid_q;
   wire wr_lane0 = wr_go && w_strb_q[0];
   wire wr_map   = (aw_addr_q == CTRL_ZERO_OFS) ||
                   (aw_addr_q == CTRL_TWO_OFS)  ||
                   (aw_addr_q == CTRL_FOUR_OFS) ||
                   (aw_addr_q == STATUS_OFS)    ||
                   (aw_addr_q == WAKE_EN_OFS)   ||
                   (aw_addr_q == CONFIG_OFS);
   wire [7:0] wbyte = w_data_q[7:0];

   always_ff @(posedge clk or negedge rst_sync_n)
   begin
      if (!rst_sync_n)
      begin
         aw_have_q <= 1'b0;
         w_have_q  <= 1'b0;
         aw_addr_q <= 8'h00;
         w_data_q  <= 32'h0000_0000;
         w_strb_q  <= 4'h0;
         bvalid_q  <= 1'b0;
         bresp_q   <= RESP_OKAY;
      end
      else if (clk_en)
      begin
         if (aw_take)
         begin
            aw_have_q <= 1'b1;
            aw_addr_q <= {s_axi_awaddr[7:2], 2'b00};
         end
         if (w_take)
         begin
            w_have_q <= 1'b1;
            w_data_q <= s_axi_wdata;
            w_strb_q <= s_axi_wstrb;
         end
         if (wr_go)
         begin
            aw_have_q <= 1'b0;
            w_have_q  <= 1'b0;
            bvalid_q  <= 1'b1;
            bresp_q   <= wr_map ? RESP_OKAY : RESP_SLVERR;
         end
         else if (bvalid_q && s_axi_bready)
            bvalid_q <= 1'b0;
      end
   end

   // Software-written control registers
   always_ff @(posedge clk or negedge rst_sync_n)
   begin
      if (!rst_sync_n)
      begin
         src_sel_q  <= SRC_SEL_RST;
         keep_q     <= KEEPALIVE_RST;
         xtal_pwr_q <= XTAL_PWR_RST;
         wake_en_q  <= WAKE_EN_RST;
         cfg_q      <= CONFIG_RST;
      end
      else if (clk_en && wr_lane0)
      begin
         case (aw_addr_q)
            CTRL_ZERO_OFS: src_sel_q  <= wbyte[SRC_SEL_BIT];
            CTRL_TWO_OFS:  keep_q     <= wbyte[KEEPALIVE_BIT];
            CTRL_FOUR_OFS: xtal_pwr_q <= wbyte[XTAL_PWR_BIT];
            WAKE_EN_OFS:   wake_en_q  <= wbyte;
            CONFIG_OFS:    cfg_q      <= wbyte[3:0];
            default:       cfg_q      <= cfg_q;
         endcase
      end
   end

   // AXI read channel
   logic        rvalid_q;
   logic [31:0] rdata_q;
   logic [1:0]  rresp_q;

   wire ar_take = s_axi_arvalid && !rvalid_q;
   wire [7:0] ar_addr = {s_axi_araddr[7:2], 2'b00};
   wire [7:0] status_byte = {state_q, 2'b00, to_q, pdf_q};
   wire [7:0] cfg_byte    = {4'h0, cfg_q};

   // Read data selection
   logic [7:0] rd_byte;
   logic       rd_ok;

   always_comb
   begin
      rd_ok   = 1'b1;
      rd_byte = 8'h00;
      case (ar_addr)
         CTRL_ZERO_OFS: rd_byte[SRC_SEL_BIT]   = src_sel_q;
         CTRL_TWO_OFS:  rd_byte[KEEPALIVE_BIT] = keep_q;
         CTRL_FOUR_OFS: rd_byte[XTAL_PWR_BIT]  = xtal_pwr_q;
         STATUS_OFS:    rd_byte = status_byte;
         WAKE_EN_OFS:   rd_byte = wake_en_q;
         CONFIG_OFS:    rd_byte = cfg_byte;
         default:       rd_ok   = 1'b0;
      endcase
   end

   always_ff @(posedge clk or negedge rst_sync_n)
   begin
      if (!rst_sync_n)
      begin
         rvalid_q <= 1'b0;
         rdata_q  <= 32'h0000_0000;
         rresp_q  <= RESP_OKAY;
      end
      else if (clk_en)
      begin
         if (ar_take)
         begin
            rvalid_q <= 1'b1;
            rdata_q  <= {24'h00_0000, rd_byte};
            rresp_q  <= rd_ok ? RESP_OKAY : RESP_SLVERR;
         end
         else if (rvalid_q && s_axi_rready)
            rvalid_q <= 1'b0;
      end
   end

   // Mode sequencer next state
   wire cnt_done = (cnt_q <= 32'd1);

   always_comb
   begin
      state_d = state_q;
      case (state_q)
         ST_RUN:  if (halt_req) state_d = ST_HALT;
         ST_HALT: if (wdt_overflow || pa_wake || irq_wake)
                     state_d = ST_WAKE;
         ST_WAKE: if (cnt_done) state_d = ST_RUN;
         ST_POR:  if (cnt_done) state_d = ST_WAKE;
         default: state_d = ST_POR;
      endcase
      if (lvr_event)
         state_d = ST_POR;
   end

   // Sequencer, delay counter and wake cause
   always_ff @(posedge clk or negedge rst_sync_n)
   begin
      if (!rst_sync_n)
      begin
         state_q   <= ST_POR;
         cnt_q     <= RESET_DLY_CYC;
         cause_q   <= WK_POR;
         irq_arm_q <= '0;
      end
      else if (clk_en)
      begin
         state_q <= state_d;
         if (cnt_q != 32'd0)
            cnt_q <= cnt_q - 32'd1;
         if (lvr_event)
         begin
            cnt_q   <= RESET_DLY_CYC;
            cause_q <= WK_POR;
         end
         else if (state_d == ST_WAKE && state_q != ST_WAKE)
            // start-up delay by oscillator and mode
            cnt_q <= startup_cyc(src_sel_q, keep_q, cfg_q.hs_is_crystal);
         // arm only interrupts idle at halt
         if (halt_go)
            irq_arm_q <= ~irq_flag;
         if (in_halt && state_d == ST_WAKE)
         begin
            if (wdt_overflow)
               cause_q <= WK_WDT;
            else if (!pa_wake && irq_serve)
               cause_q <= WK_INTR;
            else
               cause_q <= WK_RESUME;
         end
      end
   end

   // Status flags
   always_ff @(posedge clk or negedge rst_sync_n)
   begin
      if (!rst_sync_n)
      begin
         pdf_q <= 1'b0;
         to_q  <= 1'b0;
      end
      else if (clk_en)
      begin
         // set by halt, cleared by clear-watchdog
         if (halt_go)
            pdf_q <= 1'b1;
         else if (clr_wdt_req)
            pdf_q <= 1'b0;
         // overflow sets time-out, set beats clear
         if (wdt_overflow)
            to_q <= 1'b1;
         else if (halt_go)
            to_q <= 1'b0;
      end
   end

   // Oscillator controls and core strobes
   wire running = (state_q == ST_RUN) || (state_q == ST_WAKE);
   wire resume  = (state_q == ST_WAKE) && cnt_done;

   always_ff @(posedge clk or negedge rst_sync_n)
   begin
      if (!rst_sync_n)
      begin
         highspeed_osc_en        <= 1'b1;
         lowspeed_crystal_osc_en <= 1'b1;
         lowspeed_rc_osc_en      <= 1'b0;
         cpu_hold                <= 1'b1;
         wdt_clear               <= 1'b0;
         resume_after_halt       <= 1'b0;
         intr_response           <= 1'b0;
         pc_sp_reset             <= 1'b0;
      end
      else if (clk_en)
      begin
         // high-speed clock off in Idle/Sleep and Slow
         highspeed_osc_en <= (running || state_q == ST_POR) && !src_sel_q;
         // crystal kept alive on halt by keep-alive
         lowspeed_crystal_osc_en <= !in_halt || keep_q;
         lowspeed_rc_osc_en <= cfg_q.lvr_en | cfg_q.wdt_en |
                               cfg_q.sub_from_rc;
         // core held from halt until resume
         cpu_hold <= (state_d != ST_RUN);
         wdt_clear <= halt_go || clr_wdt_req;
         // port and unserved wakes resume after halt
         resume_after_halt <= resume && (cause_q == WK_RESUME);
         intr_response     <= resume && (cause_q == WK_INTR);
         pc_sp_reset       <= resume && (cause_q == WK_WDT);
      end
   end

   // Registered outputs
   assign lowspeed_xtal_power_sel = xtal_pwr_q; // low current
   assign sysclk_source_sel       = src_sel_q;
   assign power_down_flag         = pdf_q;
   assign watchdog_timeout_flag   = to_q;
   assign s_axi_awready = !aw_have_q && !bvalid_q;
   assign s_axi_wready  = !w_have_q && !bvalid_q;
   assign s_axi_bvalid  = bvalid_q;
   assign s_axi_bresp   = bresp_q;
   assign s_axi_arready = !rvalid_q;
   assign s_axi_rvalid  = rvalid_q;
   assign s_axi_rdata   = rdata_q;
   assign s_axi_rresp   = rresp_q;

endmodule

// ==== power_mode_chk.sv ====
// Checker for the power mode controller, bound to its top ports.
// Assumes one clock domain; rst_n low switches every check off.
module power_mode_chk
   import power_mode_pkg::*;
(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic clk_en,
   input wire logic halt_req,
   input wire logic clr_wdt_req,
   input wire logic wdt_overflow,
   input wire logic highspeed_osc_en,
   input wire logic lowspeed_crystal_osc_en,
   input wire logic cpu_hold,
   input wire logic wdt_clear,
   input wire logic resume_after_halt,
   input wire logic intr_response,
   input wire logic pc_sp_reset,
   input wire logic power_down_flag,
   input wire logic watchdog_timeout_flag
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking @(posedge clk);
   endclocking
   default disable iff (!rst_n);
   // Halt taken while the core runs, and the wake cause pulses
   wire       halt_go = halt_req && clk_en && !cpu_hold;
   wire [2:0] cause   = {pc_sp_reset, intr_response, resume_after_halt};
   halt_clr_a: assert property (halt_go |=> cpu_hold && wdt_clear)
      else $error("halt did not hold core and clear watchdog");
   halt_flags_a: assert property (
      halt_go && !wdt_overflow |=> power_down_flag && !watchdog_timeout_flag)
      else $error("halt left wrong status flags");
   hs_stop_a: assert property (halt_go |-> ##[1:2] !highspeed_osc_en)
      else $error("fast oscillator still on after halt");
   pdf_set_a: assert property ($rose(power_down_flag) |-> $past(halt_req))
      else $error("power-down flag set without halt");
   pdf_clr_a: assert property (
      clr_wdt_req && clk_en && !halt_go |=> !power_down_flag)
      else $error("clear-watchdog left power-down flag set");
   clr_src_a: assert property (
      wdt_clear |-> $past(halt_req) || $past(clr_wdt_req))
      else $error("watchdog clear without cause");
   cause_one_a: assert property ($onehot0(cause))
      else $error("more than one wake cause pulse");
   wdt_to_a: assert property (pc_sp_reset |-> watchdog_timeout_flag)
      else $error("watchdog wake without time-out flag");
   sleep_hold_a: assert property (!lowspeed_crystal_osc_en |-> cpu_hold)
      else $error("crystal stopped while core runs");
   // Main scenarios reached
   cover property (halt_go);
   cover property (intr_response);
   cover property (pc_sp_reset);
   cover property (resume_after_halt);
endmodule

bind power_mode_ctrl power_mode_chk u_chk (.*);

// ==== cpu_core_model.sv ====
// CPU core model: executes halt and clear-watchdog on request.
// Assumes the bench strobes go_halt and go_clr for one clk cycle.
module cpu_core_model
   import power_mode_pkg::*;
(
   input  wire logic clk,
   input  wire logic cpu_hold,
   input  wire logic go_halt,
   input  wire logic go_clr,
   output logic      halt_req = 1'h0,
   output logic      clr_wdt_req = 1'h0
);
   timeunit 1ns;
   timeprecision 1ns;
   // A held core executes nothing, so requests made while held are dropped
   always @(posedge clk)
   begin
      halt_req    <= go_halt && !cpu_hold;
      clr_wdt_req <= go_clr && !cpu_hold;
   end
endmodule

// ==== power_mode_ctrl_tb_top.sv ====
// Bench for the power mode controller: registers, halt and wake-up.
// Assumes the core model and the bound checker are compiled before it.
module power_mode_ctrl_tb_top
   import power_mode_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   localparam int unsigned RDLY = 20;
   int          checks = 0;
   int          errors = 0;
   logic        clk = 1'h0;
   logic        rst_n = 1'h0;
   logic        clk_en = 1'h1;
   logic [7:0]  s_axi_awaddr = 8'h00;
   logic        s_axi_awvalid = 1'h0;
   logic [31:0] s_axi_wdata = 32'h0;
   logic [3:0]  s_axi_wstrb = 4'hF;
   logic        s_axi_wvalid = 1'h0;
   logic        s_axi_bready = 1'h0;
   logic [7:0]  s_axi_araddr = 8'h00;
   logic        s_axi_arvalid = 1'h0;
   logic        s_axi_rready = 1'h0;
   logic        go_halt = 1'h0;
   logic        go_clr = 1'h0;
   logic        wdt_overflow = 1'h0;
   logic        lvr_event = 1'h0;
   logic [7:0]  irq_flag = 8'h00;
   logic [7:0]  irq_enable = 8'h00;
   logic        stack_full = 1'h0;
   logic [7:0]  port_a_pin = 8'hFF;
   logic [31:0] s_axi_rdata;
   logic [1:0]  s_axi_bresp, s_axi_rresp;
   logic        s_axi_awready, s_axi_wready, s_axi_bvalid;
   logic        s_axi_arready, s_axi_rvalid, halt_req, clr_wdt_req;
   logic        highspeed_osc_en, lowspeed_crystal_osc_en;
   logic        lowspeed_xtal_power_sel, lowspeed_rc_osc_en;
   logic        sysclk_source_sel, cpu_hold, wdt_clear, resume_after_halt;
   logic        intr_response, pc_sp_reset, power_down_flag;
   logic        watchdog_timeout_flag;

   // Design, with a short reset delay, and the core beside it
   power_mode_ctrl #(.RESET_DLY_CYC(RDLY)) u_dut (.*);
   cpu_core_model u_cpu (.clk(clk), .cpu_hold(cpu_hold), .go_halt(go_halt),
      .go_clr(go_clr), .halt_req(halt_req), .clr_wdt_req(clr_wdt_req));

   // 10 MHz clock
   always #50 clk = ~clk;

   task automatic chk(input string nm, input logic [31:0] got, exp);
      checks++;
      if (got !== exp)
      begin
         errors++;
         $display("[FAIL] %s expected %h seen %h", nm, exp, got);
      end
   endtask

   // Write cycle: address and data together, each held until taken
   task automatic wr(input logic [7:0] a, input logic [31:0] d,
                     input logic [1:0] er);
      @(posedge clk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'h1;
      s_axi_wvalid <= 1'h1;
      s_axi_bready <= 1'h1;
      for (int n = 0; n < 50; n++)
      begin
         @(posedge clk);
         if (s_axi_awready === 1'h1) s_axi_awvalid <= 1'h0;
         if (s_axi_wready === 1'h1) s_axi_wvalid <= 1'h0;
         if (s_axi_bvalid === 1'h1) break;
      end
      chk("bvalid", s_axi_bvalid, 1'h1);
      chk("bresp", s_axi_bresp, er);
      s_axi_bready <= 1'h0;
   endtask

   // Read cycle with data and response compare
   task automatic rdc(input string nm, input logic [7:0] a,
                      input logic [31:0] e, input logic [1:0] er);
      @(posedge clk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'h1;
      s_axi_rready <= 1'h1;
      for (int n = 0; n < 50; n++)
      begin
         @(posedge clk);
         if (s_axi_arready === 1'h1) s_axi_arvalid <= 1'h0;
         if (s_axi_rvalid === 1'h1) break;
      end
      chk("rvalid", s_axi_rvalid, 1'h1);
      chk(nm, s_axi_rdata, e);
      chk("rresp", s_axi_rresp, er);
      s_axi_rready <= 1'h0;
   endtask

   // Counts held edges until release, gathering the cause pulses
   task automatic run_wait(output int n, output logic [2:0] seen);
      seen = 3'h0;
      n = 0;
      for (int i = 0; i < 2000; i++)
      begin
         @(posedge clk);
         seen |= {pc_sp_reset, intr_response, resume_after_halt};
         if (cpu_hold === 1'h1) n = i + 1;
         if (i > n + 2) break;
      end
      chk("released", cpu_hold, 1'h0);
   endtask

   task automatic halt_now();
      @(posedge clk);
      go_halt <= 1'h1;
      @(posedge clk);
      go_halt <= 1'h0;
      repeat (3) @(posedge clk);
   endtask

   task automatic por_regs();
      logic [2:0] seen;
      int         n;
      run_wait(n, seen);
      chk("por_dly", n >= RDLY, 1'h1);
      chk("xpwr_rst", lowspeed_xtal_power_sel, 1'h0);
      rdc("control_reg_zero", CTRL_ZERO_OFS, 32'h0, RESP_OKAY);
      rdc("control_reg_two", CTRL_TWO_OFS, 32'h1, RESP_OKAY);
      rdc("control_reg_four", CTRL_FOUR_OFS, 32'h0, RESP_OKAY);
      rdc("status", STATUS_OFS, 32'h10, RESP_OKAY);
      rdc("wake_en", WAKE_EN_OFS, 32'h0, RESP_OKAY);
      rdc("config", CONFIG_OFS, 32'h0, RESP_OKAY);
      rdc("unmapped", 8'h18, 32'h0, RESP_SLVERR);
      wr(8'h18, 32'h1, RESP_SLVERR);
      wr(CTRL_FOUR_OFS, 32'h10, RESP_OKAY);
      repeat (2) @(posedge clk);
      chk("xpwr_set", lowspeed_xtal_power_sel, 1'h1);
      chk("lx_on", lowspeed_crystal_osc_en, 1'h1);
   endtask

   task automatic rc_select();
      for (int i = 0; i < 8; i++)
      begin
         wr(CONFIG_OFS, i, RESP_OKAY);
         repeat (2) @(posedge clk);
         chk("rc_osc", lowspeed_rc_osc_en, |i[2:0]);
      end
   endtask

   // Watchdog wake in five clock set-ups, {source, keep-alive, crystal}
   task automatic wake_delays();
      logic [2:0] tab [5] = '{3'h2, 3'h3, 3'h0, 3'h4, 3'h6};
      logic       src, keep, xt;
      logic [2:0] seen;
      int         n, ev, base;
      for (int i = 0; i < 5; i++)
      begin
         {src, keep, xt} = tab[i];
         ev = src ? (keep ? SHORT_STARTUP_CYC : LONG_STARTUP_CYC)
                  : (xt ? LONG_STARTUP_CYC : SHORT_STARTUP_CYC);
         wr(CONFIG_OFS, {28'h0, xt, 3'h2}, RESP_OKAY);
         wr(CTRL_ZERO_OFS, {31'h0, src}, RESP_OKAY);
         wr(CTRL_TWO_OFS, {31'h0, keep}, RESP_OKAY);
         halt_now();
         chk("hs_halt", highspeed_osc_en, 1'h0);
         chk("halt_any", cpu_hold, 1'h1);
         chk("lx_halt", lowspeed_crystal_osc_en, keep);
         chk("rc_halt", lowspeed_rc_osc_en, 1'h1);
         rdc("st_halt", STATUS_OFS, 32'h21, RESP_OKAY);
         @(posedge clk);
         wdt_overflow <= 1'h1;
         @(posedge clk);
         wdt_overflow <= 1'h0;
         run_wait(n, seen);
         if (i == 0) base = n - ev;
         chk("wake_dly", n - base, ev);
         chk("wdt_cause", seen, 3'h4);
         chk("to_flag", watchdog_timeout_flag, 1'h1);
         chk("hs_run", highspeed_osc_en, !src);
         chk("src_pin", sysclk_source_sel, src);
         rdc("src_kept", CTRL_ZERO_OFS, {31'h0, src}, RESP_OKAY);
      end
   endtask

   // Interrupt wakes, {enabled, stack full, flagged before halt}
   task automatic irq_wakes();
      logic [2:0] tab [4] = '{3'h4, 3'h0, 3'h6, 3'h5};
      logic       e, f, p;
      logic [2:0] seen;
      int         n;
      wr(CONFIG_OFS, 32'h0, RESP_OKAY);
      wr(CTRL_ZERO_OFS, 32'h0, RESP_OKAY);
      wr(CTRL_TWO_OFS, 32'h1, RESP_OKAY);
      wr(WAKE_EN_OFS, 32'h08, RESP_OKAY);
      for (int i = 0; i < 4; i++)
      begin
         {e, f, p} = tab[i];
         @(posedge clk);
         irq_enable <= {7'h0, e};
         stack_full <= f;
         irq_flag <= {7'h0, p};
         halt_now();
         if (p)
         begin
            repeat (300) @(posedge clk);
            chk("pre_flag", cpu_hold, 1'h1);
            port_a_pin <= 8'hDF;
            repeat (20) @(posedge clk);
            chk("pin_off", cpu_hold, 1'h1);
            port_a_pin <= 8'hD7;
         end
         else
            irq_flag <= 8'h01;
         run_wait(n, seen);
         chk("irq_cause", seen, (e && !f && !p) ? 3'h2 : 3'h1);
         irq_flag <= 8'h00;
         port_a_pin <= 8'hFF;
      end
   endtask

   task automatic clr_pdf();
      chk("pdf_kept", power_down_flag, 1'h1);
      @(posedge clk);
      go_clr <= 1'h1;
      @(posedge clk);
      go_clr <= 1'h0;
      repeat (4) @(posedge clk);
      chk("pdf_clr", power_down_flag, 1'h0);
   endtask

   task automatic lvr_restart();
      logic [2:0] seen;
      int         n;
      @(posedge clk);
      lvr_event <= 1'h1;
      @(posedge clk);
      lvr_event <= 1'h0;
      run_wait(n, seen);
      chk("lvr_dly", n >= RDLY, 1'h1);
      rdc("lvr_keep", WAKE_EN_OFS, 32'h08, RESP_OKAY);
   endtask

   // Power-on while halted gives a full reset
   task automatic halt_reset();
      logic [2:0] seen;
      int         n;
      halt_now();
      rst_n <= 1'h0;
      repeat (3) @(posedge clk);
      rst_n <= 1'h1;
      run_wait(n, seen);
      chk("por_pdf", power_down_flag, 1'h0);
      chk("por_cause", seen, 3'h0);
      rdc("por_wake", WAKE_EN_OFS, 32'h0, RESP_OKAY);
      chk("por_xpwr", lowspeed_xtal_power_sel, 1'h0);
   endtask

   task automatic conclude();
      $display("checks %0d errors %0d", checks, errors);
      if (errors == 0 && checks > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask

   // Main sequence
   initial
   begin
      repeat (20) @(posedge clk);
      rst_n <= 1'h1;
      por_regs();
      rc_select();
      wake_delays();
      irq_wakes();
      clr_pdf();
      lvr_restart();
      halt_reset();
      conclude();
   end

   // Watchdog against a hang
   initial
   begin
      repeat (20000) @(posedge clk);
      errors++;
      conclude();
   end
endmodule
